// ### rtl/cqm_map.svh
// Register map, field positions, reset values and counts of the channel quality monitor
// Assumes a 32-bit APB slave with word-aligned registers
`ifndef CQM_MAP_SVH
`define CQM_MAP_SVH

`define CQM_CFG_OFS 12'h000
`define CQM_MSE_OFS 12'h004
`define CQM_MSE_WORST_OFS 12'h008
`define CQM_SQI_OFS 12'h00C
`define CQM_PEAK_OFS 12'h010
`define CQM_SLICER_OFS 12'h014
`define CQM_STATUS_OFS 12'h018
`define CQM_THR_BASE_OFS 12'h020

`define CQM_CFG_EN_BIT 0
`define CQM_CFG_SQU_BIT 1
`define CQM_CFG_CAP_BIT 2
`define CQM_CFG_CHAN_LSB 4
`define CQM_CFG_MFS_LSB 8
`define CQM_CFG_PFS_LSB 12
`define CQM_CFG_MSS_LSB 16
`define CQM_CFG_PSS_LSB 20
`define CQM_SQI_WORST_LSB 4
`define CQM_PEAK_WORST_LSB 8
`define CQM_STATUS_DROP_LSB 16

`define CQM_THR_RST_STEP 9'h040
`define CQM_MSE_MAX 9'h1FF
`define CQM_PEAK_MAX 6'h3F
`define CQM_PEAK_SCALE_ADD 5'h03
`define CQM_SQI_BEST 3'h7
`define CQM_PERIOD_SYMBOLS 65536
`define CQM_PERIOD_US 524288

`define CQM_LVL_HI 10'sh080
`define CQM_LVL_MID 10'sh040
`define CQM_THR_FAST 10'sh040
`define CQM_THR_GIG_OUT 10'sh060
`define CQM_THR_GIG_IN 10'sh020
`define CQM_ERR_GIG 10'sh020
`define CQM_ERR_FAST 10'sh040

`endif

// ### rtl/cqm_pkg.sv
// Types shared by the channel quality monitor
// Assumes cqm_map.svh supplies the numeric constants
package cqm_pkg;

    localparam int PAIRS = 4;
    localparam int FRAC = 8;
    localparam int ACC_W = 13 + FRAC;

    typedef enum logic {
        MODE_FAST = 1'b0,
        MODE_GIG = 1'b1
    } rx_mode_e;

    typedef logic [ACC_W-1:0] acc_t;

    typedef struct packed {
        logic en;
        logic squ;
        logic [1:0] chan;
        logic [3:0] mfs;
        logic [3:0] pfs;
        logic [3:0] mss;
        logic [3:0] pss;
        logic [7:1][8:0] thr;
        logic [15:0] sym_cnt;
        logic [PAIRS-1:0][ACC_W-1:0] mean_f;
        logic [PAIRS-1:0][ACC_W-1:0] peak_f;
        logic [PAIRS-1:0][ACC_W-1:0] peak_max;
        logic [PAIRS-1:0][12:0] slicer_lat;
        logic [PAIRS-1:0][8:0] mse_lat;
        logic [PAIRS-1:0][8:0] mse_worst;
        logic [PAIRS-1:0][2:0] sqi_lat;
        logic [PAIRS-1:0][2:0] sqi_worst;
        logic [PAIRS-1:0][5:0] peak_lat;
        logic [PAIRS-1:0][5:0] peak_worst;
        logic [8:0] cap_mse;
        logic [8:0] cap_mse_worst;
        logic [2:0] cap_sqi;
        logic [2:0] cap_sqi_worst;
        logic [5:0] cap_peak;
        logic [5:0] cap_peak_worst;
        logic [12:0] cap_slicer;
        logic [PAIRS-1:0] link_drop;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_s;

endpackage

// ### rtl/channel_quality_monitor.sv
// Channel quality monitor: slicer error filtering, mean/peak/quality results per receive pair
// Assumes samples arrive on pclk from the receiver, all pairs together on one strobe
`timescale 1ns/1ns
`include "cqm_map.svh"

module channel_quality_monitor import cqm_pkg::*; #(
    parameter int SYMBOLS_PER_PERIOD = `CQM_PERIOD_SYMBOLS
) (
    input wire logic pclk, // Bus and symbol clock, 125 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic sample_valid, // One symbol on every pair
    input wire logic [PAIRS*10-1:0] sample_data, // Signed 10-bit equalised sample per pair
    input wire logic rx_mode, // 1 gigabit five-level, 0 fast three-level
    output logic [PAIRS-1:0] link_drop // Pair quality index is 0
);

    localparam logic [15:0] PERIOD_LAST = 16'(SYMBOLS_PER_PERIOD - 1);

    state_s st_ff;
    state_s nxt_st;

    //------------------------------------------------------------
    // Reset value
    //------------------------------------------------------------
    function automatic state_s rst_state();
        state_s s;
        s = '0;
        for (int n = 1; n <= 7; n++) begin
            s.thr[n] = 9'(`CQM_THR_RST_STEP * (8 - n));
        end
        s.sqi_lat = {PAIRS{`CQM_SQI_BEST}};
        s.sqi_worst = {PAIRS{`CQM_SQI_BEST}};
        s.cap_sqi = `CQM_SQI_BEST;
        s.cap_sqi_worst = `CQM_SQI_BEST;
        return s;
    endfunction

    localparam state_s RST_STATE = rst_state();

    //------------------------------------------------------------
    // Slicer: scaled error of one sample
    //------------------------------------------------------------
    function automatic logic [12:0] slice_err(input logic signed [9:0] smp, input logic gig, input logic squ);
        logic signed [9:0] lvl;
        logic signed [9:0] err;
        logic [6:0] mag;
        lvl = '0;
        err = '0;
        mag = '0;
        if (gig) begin
            if (smp > `CQM_THR_GIG_OUT) begin
                lvl = `CQM_LVL_HI;
            end else if (smp > `CQM_THR_GIG_IN) begin
                lvl = `CQM_LVL_MID;
            end else if (smp >= -`CQM_THR_GIG_IN) begin
                lvl = '0;
            end else if (smp >= -`CQM_THR_GIG_OUT) begin
                lvl = -`CQM_LVL_MID;
            end else begin
                lvl = -`CQM_LVL_HI;
            end
        end else begin
            if (smp > `CQM_THR_FAST) begin
                lvl = `CQM_LVL_HI;
            end else if (smp >= -`CQM_THR_FAST) begin
                lvl = '0;
            end else begin
                lvl = -`CQM_LVL_HI;
            end
        end
        err = smp - lvl;
        if (gig) begin
            if (err > `CQM_ERR_GIG) begin
                err = `CQM_ERR_GIG;
            end else if (err < -`CQM_ERR_GIG) begin
                err = -`CQM_ERR_GIG;
            end
        end else begin
            if (err > `CQM_ERR_FAST) begin
                err = `CQM_ERR_FAST;
            end else if (err < -`CQM_ERR_FAST) begin
                err = -`CQM_ERR_FAST;
            end
        end
        mag = 7'(err < 0 ? -err : err);
        if (gig) begin
            mag = 7'({mag[5:0], 1'b0});
        end
        if (squ) begin
            return 13'(mag * mag);
        end
        return 13'(mag);
    endfunction

    //------------------------------------------------------------
    // One low-pass step: f += (x - f) / 2^shift
    //------------------------------------------------------------
    function automatic acc_t lp_step(input acc_t f, input logic [12:0] x, input logic [3:0] shift);
        logic signed [ACC_W:0] diff;
        logic signed [ACC_W:0] sum;
        diff = $signed({1'b0, x, {FRAC{1'b0}}}) - $signed({1'b0, f});
        sum = $signed({1'b0, f}) + (diff >>> shift);
        return acc_t'(sum[ACC_W-1:0]);
    endfunction

    //------------------------------------------------------------
    // Result scaling and saturation
    //------------------------------------------------------------
    function automatic logic [8:0] mse_of(input acc_t f, input logic [3:0] sc);
        logic [12:0] v;
        v = 13'(f[ACC_W-1:FRAC] >> sc);
        return (v > 13'(`CQM_MSE_MAX)) ? `CQM_MSE_MAX : v[8:0];
    endfunction

    function automatic logic [5:0] peak_of(input acc_t f, input logic [3:0] sc);
        logic [12:0] v;
        v = 13'(f[ACC_W-1:FRAC] >> (5'(sc) + `CQM_PEAK_SCALE_ADD));
        return (v > 13'(`CQM_PEAK_MAX)) ? `CQM_PEAK_MAX : v[5:0];
    endfunction

    //------------------------------------------------------------
    // Quality index from the threshold table
    //------------------------------------------------------------
    function automatic logic [2:0] sqi_of(input logic [8:0] m, input logic [7:1][8:0] thr);
        logic [2:0] q;
        q = '0;
        for (int n = 1; n <= 7; n++) begin
            if (m <= thr[n]) begin
                q = 3'(n);
            end
        end
        return q;
    endfunction

    //------------------------------------------------------------
    // Register read mux
    //------------------------------------------------------------
    function automatic logic [32:0] rd_word(input state_s s, input logic [11:0] a);
        logic [32:0] r;
        r = '0;
        case (a)
            `CQM_CFG_OFS: begin
                r[`CQM_CFG_EN_BIT] = s.en;
                r[`CQM_CFG_SQU_BIT] = s.squ;
                r[`CQM_CFG_CHAN_LSB +: 2] = s.chan;
                r[`CQM_CFG_MFS_LSB +: 4] = s.mfs;
                r[`CQM_CFG_PFS_LSB +: 4] = s.pfs;
                r[`CQM_CFG_MSS_LSB +: 4] = s.mss;
                r[`CQM_CFG_PSS_LSB +: 4] = s.pss;
            end
            `CQM_MSE_OFS: begin
                r[8:0] = s.cap_mse;
            end
            `CQM_MSE_WORST_OFS: begin
                r[8:0] = s.cap_mse_worst;
            end
            `CQM_SQI_OFS: begin
                r[2:0] = s.cap_sqi;
                r[`CQM_SQI_WORST_LSB +: 3] = s.cap_sqi_worst;
            end
            `CQM_PEAK_OFS: begin
                r[5:0] = s.cap_peak;
                r[`CQM_PEAK_WORST_LSB +: 6] = s.cap_peak_worst;
            end
            `CQM_SLICER_OFS: begin
                r[12:0] = s.cap_slicer;
            end
            `CQM_STATUS_OFS: begin
                for (int p = 0; p < PAIRS; p++) begin
                    r[4*p +: 3] = s.sqi_lat[p];
                end
                r[`CQM_STATUS_DROP_LSB +: PAIRS] = s.link_drop;
            end
            default: begin
                r[32] = 1'b1;
                for (int n = 1; n <= 7; n++) begin
                    if (a == 12'(`CQM_THR_BASE_OFS + 4 * (n - 1))) begin
                        r[8:0] = s.thr[n];
                        r[32] = 1'b0;
                    end
                end
            end
        endcase
        return r;
    endfunction

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        logic setup;
        logic access;
        logic wr;
        logic rd;
        logic period_end;
        logic [32:0] rw;
        logic [12:0] x;
        logic [8:0] m;
        logic [2:0] q;
        logic [5:0] pk;
        acc_t pmax;
        setup = psel & ~penable;
        access = psel & penable & st_ff.pready;
        wr = access & pwrite;
        rd = access & ~pwrite;
        period_end = 1'b0;
        rw = '0;
        x = '0;
        m = '0;
        q = '0;
        pk = '0;
        pmax = '0;
        nxt_st = st_ff;

        // Bus answer, zero wait states
        nxt_st.pready = setup;
        nxt_st.pslverr = 1'b0;
        if (setup) begin
            rw = rd_word(st_ff, paddr);
            nxt_st.pslverr = rw[32];
            nxt_st.prdata = pwrite ? 32'h0000_0000 : rw[31:0];
        end

        // Symbol period and filters
        if (st_ff.en && sample_valid) begin
            period_end = (st_ff.sym_cnt == PERIOD_LAST);
            nxt_st.sym_cnt = period_end ? 16'h0000 : 16'(st_ff.sym_cnt + 16'h0001);
            for (int p = 0; p < PAIRS; p++) begin
                x = slice_err($signed(sample_data[10*p +: 10]), rx_mode == MODE_GIG, st_ff.squ);
                nxt_st.mean_f[p] = lp_step(st_ff.mean_f[p], x, st_ff.mfs);
                nxt_st.peak_f[p] = lp_step(st_ff.peak_f[p], x, st_ff.pfs);
                pmax = (nxt_st.peak_f[p] > st_ff.peak_max[p]) ? nxt_st.peak_f[p] : st_ff.peak_max[p];
                nxt_st.peak_max[p] = period_end ? '0 : pmax;
                if (period_end) begin
                    m = mse_of(nxt_st.mean_f[p], st_ff.mss);
                    q = sqi_of(m, st_ff.thr);
                    pk = peak_of(pmax, st_ff.pss);
                    nxt_st.slicer_lat[p] = nxt_st.mean_f[p][ACC_W-1:FRAC];
                    nxt_st.mse_lat[p] = m;
                    nxt_st.sqi_lat[p] = q;
                    nxt_st.peak_lat[p] = pk;
                    nxt_st.link_drop[p] = (q == 3'h0);
                end
            end
        end

        // Worst values: clear on read of the captured pair, new latch wins
        for (int p = 0; p < PAIRS; p++) begin
            if (rd && paddr == `CQM_MSE_OFS && st_ff.chan == 2'(p)) begin
                nxt_st.mse_worst[p] = '0;
                nxt_st.sqi_worst[p] = `CQM_SQI_BEST;
            end
            if (rd && paddr == `CQM_PEAK_OFS && st_ff.chan == 2'(p)) begin
                nxt_st.peak_worst[p] = '0;
            end
            if (period_end) begin
                if (nxt_st.mse_lat[p] > nxt_st.mse_worst[p]) begin
                    nxt_st.mse_worst[p] = nxt_st.mse_lat[p];
                end
                if (nxt_st.sqi_lat[p] < nxt_st.sqi_worst[p]) begin
                    nxt_st.sqi_worst[p] = nxt_st.sqi_lat[p];
                end
                if (nxt_st.peak_lat[p] > nxt_st.peak_worst[p]) begin
                    nxt_st.peak_worst[p] = nxt_st.peak_lat[p];
                end
            end
        end

        // Register writes
        if (wr && pstrb == 4'hF) begin
            case (paddr)
                `CQM_CFG_OFS: begin
                    nxt_st.en = pwdata[`CQM_CFG_EN_BIT];
                    nxt_st.squ = pwdata[`CQM_CFG_SQU_BIT];
                    nxt_st.chan = pwdata[`CQM_CFG_CHAN_LSB +: 2];
                    nxt_st.mfs = pwdata[`CQM_CFG_MFS_LSB +: 4];
                    nxt_st.pfs = pwdata[`CQM_CFG_PFS_LSB +: 4];
                    nxt_st.mss = pwdata[`CQM_CFG_MSS_LSB +: 4];
                    nxt_st.pss = pwdata[`CQM_CFG_PSS_LSB +: 4];
                    if (!pwdata[`CQM_CFG_EN_BIT]) begin
                        nxt_st.sym_cnt = '0;
                        nxt_st.mean_f = '0;
                        nxt_st.peak_f = '0;
                        nxt_st.peak_max = '0;
                    end
                end
                default: begin
                    for (int n = 1; n <= 7; n++) begin
                        if (paddr == 12'(`CQM_THR_BASE_OFS + 4 * (n - 1))) begin
                            nxt_st.thr[n] = pwdata[8:0];
                        end
                    end
                end
            endcase
        end

        // Capture: bit never stored, pair results copied at once
        if (wr && pstrb == 4'hF && paddr == `CQM_CFG_OFS && pwdata[`CQM_CFG_CAP_BIT]) begin
            nxt_st.cap_mse = nxt_st.mse_lat[pwdata[`CQM_CFG_CHAN_LSB +: 2]];
            nxt_st.cap_mse_worst = nxt_st.mse_worst[pwdata[`CQM_CFG_CHAN_LSB +: 2]];
            nxt_st.cap_sqi = nxt_st.sqi_lat[pwdata[`CQM_CFG_CHAN_LSB +: 2]];
            nxt_st.cap_sqi_worst = nxt_st.sqi_worst[pwdata[`CQM_CFG_CHAN_LSB +: 2]];
            nxt_st.cap_peak = nxt_st.peak_lat[pwdata[`CQM_CFG_CHAN_LSB +: 2]];
            nxt_st.cap_peak_worst = nxt_st.peak_worst[pwdata[`CQM_CFG_CHAN_LSB +: 2]];
            nxt_st.cap_slicer = nxt_st.slicer_lat[pwdata[`CQM_CFG_CHAN_LSB +: 2]];
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= RST_STATE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    //------------------------------------------------------------
    // Outputs straight from the state register
    //------------------------------------------------------------
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign link_drop = st_ff.link_drop;

endmodule

// ### dv/cqm_checker.sv
// Assertions on the ports of the channel quality monitor
// Assumes it is bound to channel_quality_monitor from the testbench top
`timescale 1ns/1ns
`include "cqm_map.svh"
module cqm_checker import cqm_pkg::*; #(
    parameter int SYMBOLS_PER_PERIOD = `CQM_PERIOD_SYMBOLS
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [3:0] pstrb, // Strobes
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic sample_valid, // Symbol strobe
    input wire logic [PAIRS*10-1:0] sample_data, // Samples
    input wire logic rx_mode, // Line mode
    input wire logic [PAIRS-1:0] link_drop // Drop flags
);
    logic rd;
    logic mapped;
    assign rd = pready && !pwrite;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018}
        || (paddr >= `CQM_THR_BASE_OFS && paddr <= 12'h038);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----
    // Bus answer and result fields
    // ----
    property p_rdy_answer; psel && !penable |=> pready && penable; endproperty
    a_rdy_answer: assert property (p_rdy_answer) else $error("no ready after setup");
    property p_rdy_once; pready |=> !pready; endproperty
    a_rdy_once: assert property (p_rdy_once) else $error("ready held two cycles");
    property p_err_map; pready && paddr[1:0] == 2'h0 |-> pslverr == !mapped; endproperty
    a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
    property p_cap_clear; rd && paddr == `CQM_CFG_OFS |-> !prdata[`CQM_CFG_CAP_BIT]; endproperty
    a_cap_clear: assert property (p_cap_clear) else $error("capture bit reads set");
    property p_mse_range; rd && paddr inside {12'h004, 12'h008} |-> prdata[31:9] == 23'h0; endproperty
    a_mse_range: assert property (p_mse_range) else $error("mean result above 511");
    property p_sqi_worst; rd && paddr == `CQM_SQI_OFS |-> prdata[6:4] <= prdata[2:0]; endproperty
    a_sqi_worst: assert property (p_sqi_worst) else $error("worst index above current");
    property p_peak_worst;
        rd && paddr == `CQM_PEAK_OFS |-> prdata[13:8] >= prdata[5:0] && prdata[7:6] == 2'h0;
    endproperty
    a_peak_worst: assert property (p_peak_worst) else $error("worst peak below current");
    property p_drop_status;
        rd && paddr == `CQM_STATUS_OFS |->
            prdata[19:16] == {prdata[14:12] == 3'h0, prdata[10:8] == 3'h0, prdata[6:4] == 3'h0, prdata[2:0] == 3'h0};
    endproperty
    a_drop_status: assert property (p_drop_status) else $error("drop flags disagree with index");
    property p_drop_hold; !$stable(link_drop) |-> $past(sample_valid) || $past(psel && pwrite); endproperty
    a_drop_hold: assert property (p_drop_hold) else $error("drop flags moved without cause");
    property p_reset; $rose(presetn) |-> !pready && link_drop == 4'h0; endproperty
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
    c_mse_read: cover property (rd && paddr == `CQM_MSE_OFS);
    c_drop: cover property (link_drop != 4'h0);
    c_err: cover property (pready && pslverr);
endmodule

// ### dv/channel_quality_monitor_tb.sv
// Self-checking testbench of the channel quality monitor
// Sets the period of the design to 16 symbols through SYMBOLS_PER_PERIOD
`timescale 1ns/1ns
`include "cqm_map.svh"
module channel_quality_monitor_tb import cqm_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic sample_valid = 0, rx_mode = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic [3:0] pstrb = 4'hF, link_drop;
    logic [39:0] sample_data = 40'h0;
    logic re;
    int err_total = 0, n_compared = 0, cyc = 0;

    channel_quality_monitor #(.SYMBOLS_PER_PERIOD(16)) u_channel_quality_monitor (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data),
        .rx_mode(rx_mode), .link_drop(link_drop));

    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            $display("[ERR] %0t timeout before all tests ended", $time);
            err_total++;
            tally_and_finish();
        end
    end

    // ----
    // Shared tasks and reference model
    // ----
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rq, exp);
    endtask
    task automatic period(input logic [39:0] d);
        repeat (16) begin
            sample_valid <= 1'b1;
            sample_data <= d;
            @(posedge pclk);
        end
        sample_valid <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic longint xval(int s, logic gig, logic sq);
        int l;
        int e;
        if (gig) l = s > 96 ? 128 : s > 32 ? 64 : s < -96 ? -128 : s < -32 ? -64 : 0;
        else l = s > 64 ? 128 : s < -64 ? -128 : 0;
        e = s - l;
        if (e < 0) e = -e;
        if (e > (gig ? 32 : 64)) e = gig ? 32 : 64;
        if (gig) e = e * 2;
        return sq ? e * e : e;
    endfunction
    function automatic longint filt(longint x, int sh);
        longint f;
        f = 0;
        repeat (64) f = f + (((x <<< 8) - f) >>> sh);
        return f >>> 8;
    endfunction
    function automatic logic [2:0] sqi(longint m);
        for (int n = 7; n > 0; n--) if (m <= 64 * (8 - n)) return 3'(n);
        return 3'h0;
    endfunction

    // ----
    // Scenarios
    // ----
    task automatic reset_values();
        rdchk(`CQM_CFG_OFS, 32'h0);
        for (int n = 1; n < 8; n++) rdchk(`CQM_THR_BASE_OFS + 12'(4 * (n - 1)), 32'(64 * (8 - n)));
        rdchk(`CQM_SQI_OFS, 32'h77);
        rdchk(`CQM_MSE_OFS, 32'h0);
        apb(1'b0, 12'h01C, 32'h0);
        chk(32'(re), 32'h1);
        chk(rq, 32'h0);
        pstrb <= 4'h1;
        apb(1'b1, `CQM_THR_BASE_OFS, 32'h0000_01F0);
        pstrb <= 4'hF;
        rdchk(`CQM_THR_BASE_OFS, 32'h0000_01C0);
        apb(1'b1, `CQM_THR_BASE_OFS, 32'h0000_01F0);
        rdchk(`CQM_THR_BASE_OFS, 32'h0000_01F0);
        apb(1'b1, `CQM_THR_BASE_OFS, 32'h0000_01C0);
        $display("reset values done");
    endtask
    task automatic measure(input logic gig, input logic sq, input logic [3:0] mfs, input logic [3:0] pfs,
        input logic [3:0] mss, input logic [3:0] pss, input int s [4]);
        logic [31:0] cfg;
        logic [3:0] drop;
        longint x, m, k;
        cfg = {8'h00, pss, mss, pfs, mfs, 6'h00, sq, 1'b1};
        drop = 4'h0;
        rx_mode <= gig;
        apb(1'b1, `CQM_CFG_OFS, 32'h0);
        apb(1'b1, `CQM_CFG_OFS, cfg);
        repeat (4) period({10'(s[3]), 10'(s[2]), 10'(s[1]), 10'(s[0])});
        for (int p = 0; p < 4; p++) begin
            x = xval(s[p], gig, sq);
            m = filt(x, mfs) >> mss;
            if (m > 511) m = 511;
            k = filt(x, pfs) >> (pss + 3);
            if (k > 63) k = 63;
            drop[p] = sqi(m) == 3'h0;
            apb(1'b1, `CQM_CFG_OFS, cfg | 32'(p << 4) | 32'h4);
            rdchk(`CQM_MSE_OFS, 32'(m));
            rdchk(`CQM_SLICER_OFS, 32'(filt(x, mfs)));
            apb(1'b0, `CQM_SQI_OFS, 32'h0);
            chk(32'(rq[2:0]), 32'(sqi(m)));
            apb(1'b0, `CQM_PEAK_OFS, 32'h0);
            chk(32'(rq[5:0]), 32'(k));
        end
        chk(32'(link_drop), 32'(drop));
        apb(1'b0, `CQM_STATUS_OFS, 32'h0);
        chk(32'(rq[19:16]), 32'(drop));
        rdchk(`CQM_CFG_OFS, cfg | 32'h30);
        $display("measure case done");
    endtask
    task automatic worst_case();
        rx_mode <= 1'b1;
        apb(1'b1, `CQM_CFG_OFS, 32'h0);
        apb(1'b1, `CQM_CFG_OFS, 32'h0002_0003);
        period({4{10'h028}});
        apb(1'b1, `CQM_CFG_OFS, 32'h0033_0003);
        period({4{10'h028}});
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `CQM_CFG_OFS, 32'h0033_0007);
            rdchk(`CQM_MSE_OFS, 32'h120);
            rdchk(`CQM_MSE_WORST_OFS, i ? 32'h120 : 32'h1FF);
            rdchk(`CQM_SQI_OFS, i ? 32'h33 : 32'h03);
            rdchk(`CQM_PEAK_OFS, i ? 32'h2424 : 32'h3F24);
            period({4{10'h028}});
        end
        $display("worst case done");
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_values();
        measure(1'b0, 1'b0, 4'h0, 4'h0, 4'h0, 4'h0, '{10, 64, 65, -200});
        measure(1'b1, 1'b1, 4'h0, 4'h0, 4'h2, 4'h0, '{40, -100, 20, 130});
        measure(1'b1, 1'b1, 4'h1, 4'h2, 4'h3, 4'h1, '{40, 90, -33, 0});
        measure(1'b0, 1'b0, 4'h2, 4'h0, 4'h1, 4'h2, '{-30, 100, 0, 127});
        worst_case();
        tally_and_finish();
    end
endmodule

bind channel_quality_monitor cqm_checker #(.SYMBOLS_PER_PERIOD(SYMBOLS_PER_PERIOD)) u_cqm_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data),
    .rx_mode(rx_mode), .link_drop(link_drop));
